// file: rtl/pbl_defs.svh
// register offsets, control and status bit positions, reset values and timing counts
`ifndef PBL_DEFS_SVH
`define PBL_DEFS_SVH

`define PBL_OFF_CTRL       32'hFFFF0780
`define PBL_OFF_STATUS     32'hFFFF0784
`define PBL_OFF_SYNC_TMR   32'hFFFF0788
`define PBL_OFF_WIDTH_TMR  32'hFFFF078C
`define PBL_OFF_FRAME_CHK  32'hFFFF0790
`define PBL_OFF_CAPTURE    32'hFFFF0794
`define PBL_OFF_COMPARE    32'hFFFF0798

`define PBL_CTL_WAKE_EN    3
`define PBL_CTL_CMP_EN     5
`define PBL_CTL_LINK_MODE  6
`define PBL_CTL_WIDTH_EN   8
`define PBL_CTL_DRIVE_LOW  12
`define PBL_CTL_AUTO_REL   13

`define PBL_STA_WAKE       0
`define PBL_STA_WIDTH_DONE 1
`define PBL_STA_CMP        3
`define PBL_STA_CLASS_LO   4

`define PBL_RST_CTRL       16'h0000
`define PBL_RST_CAPTURE    16'h0000
`define PBL_RST_COMPARE    16'h0000

// main clock, sync timer clock, low-power oscillator and link bit rate, in Hz
`define PBL_MCLK_HZ        50000000
`define PBL_SYNC_HZ        5000000
`define PBL_LPOSC_HZ       131000
`define PBL_BIT_RATE       1200
`define PBL_SYNC_DIV       (`PBL_MCLK_HZ / `PBL_SYNC_HZ)
// low-pulse class limits in sixteenths of a bit period
`define PBL_SYNC_MAX_16TH  4
`define PBL_ZERO_MAX_16TH  9
`define PBL_ONE_MAX_16TH   15

`endif

// file: rtl/pbl_pkg.sv
// types shared by the pulse-width link timing assist
`default_nettype none

package pbl_pkg;

  // class of the last measured low pulse
  typedef enum logic [1:0] {
    PBL_BIT_SYNC    = 2'h0,
    PBL_BIT_ZERO    = 2'h1,
    PBL_BIT_ONE     = 2'h2,
    PBL_BIT_INVALID = 2'h3
  } pbl_bit_class_t;

  // state of the low-pulse width timer
  typedef enum logic [0:0] {
    PBL_WT_IDLE,
    PBL_WT_RUN
  } pbl_wt_state_t;

endpackage : pbl_pkg

`default_nettype wire

// file: rtl/pbl_low_pulse_timer.sv
// low-pulse width timer clocked by mclk, counting ticks of the low-power oscillator
`default_nettype none

module pbl_low_pulse_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             enable,
  input  wire logic             fall,
  input  wire logic             rise,
  input  wire logic             osc_tick,
  output logic [WIDTH-1:0]      count_reg,
  output logic                  done,
  output logic                  running
);

  pbl_pkg::pbl_wt_state_t state_reg;

  //////////////////////////////////////////////////////////////////////////////
  // clear and start on falling edge, stop on rising edge
  always_ff @(posedge mclk)
  begin
    if (reset)
      state_reg <= pbl_pkg::PBL_WT_IDLE;
    else if (!enable)
      state_reg <= pbl_pkg::PBL_WT_IDLE;
    else
      case (state_reg)
        pbl_pkg::PBL_WT_IDLE: if (fall) state_reg <= pbl_pkg::PBL_WT_RUN;
        pbl_pkg::PBL_WT_RUN:  if (rise) state_reg <= pbl_pkg::PBL_WT_IDLE;
        default:              state_reg <= pbl_pkg::PBL_WT_IDLE;
      endcase
  end

  // count oscillator ticks while the line is low
  always_ff @(posedge mclk)
  begin
    if (reset)
      count_reg <= '0;
    else if (enable && fall && state_reg == pbl_pkg::PBL_WT_IDLE)
      count_reg <= '0;
    else if (state_reg == pbl_pkg::PBL_WT_RUN && osc_tick && count_reg != '1)
      count_reg <= count_reg + 1'b1;
  end

  // completion pulse and running level
  assign done    = enable && rise && state_reg == pbl_pkg::PBL_WT_RUN;
  assign running = state_reg == pbl_pkg::PBL_WT_RUN;

endmodule : pbl_low_pulse_timer

`default_nettype wire

// file: rtl/pbl_link_assist.sv
// timing assist for the pulse-width coded single-wire link, slave node side
`include "pbl_defs.svh"
`default_nettype none

// What this block does
// - sync timer free-runs at 5 MHz in link mode
// - falling edge copies sync timer into capture
// - control bit 6 enables link mode features
// - compare enabled and match sets status bit 3
// - width timer clears on fall, stops on rise
// - width timer counts low-power oscillator ticks
// - sync one unit, zero three, one six
// - slave pulls low before sync time, holds
// - frame field order pause through acknowledge
// - pause is three or more sync pulses
// - direction zero master, one slave request
// - register address bit 3 selects write
// - header parity is odd parity of eight bits
// - payload parity is odd parity of data
// - master read: slave returns data, parity, ack
// - slave always sends acknowledge, zero on success
// - start-condition enable wakes core on falling edge
// - link runs 1200 bps, 19-bit frames
module pbl_link_assist #(
  parameter int TMR_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [31:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              bus_in,
  output logic                   bus_out,
  output logic                   bus_oe_n,
  input  wire logic              lp_osc,
  output logic                   cmp_irq,
  output logic                   width_irq,
  output logic                   wake_irq
);

  localparam logic [3:0] SYNC_DIV_LAST = 4'(`PBL_SYNC_DIV - 1);
  // class limits in oscillator ticks of one sixteenth bit period
  localparam int UNIT16 = `PBL_LPOSC_HZ / (16 * `PBL_BIT_RATE);
  localparam logic [TMR_W-1:0] SYNC_MAX = TMR_W'(`PBL_SYNC_MAX_16TH * UNIT16);
  localparam logic [TMR_W-1:0] ZERO_MAX = TMR_W'(`PBL_ZERO_MAX_16TH * UNIT16);
  localparam logic [TMR_W-1:0] ONE_MAX  = TMR_W'(`PBL_ONE_MAX_16TH * UNIT16);

  // odd parity of a byte: one when the count of ones is odd
  function automatic logic odd_parity(input logic [7:0] v);
    odd_parity = ^v;
  endfunction : odd_parity

  logic [15:0]       ctrl_reg;
  logic [5:0]        status_reg;
  logic [TMR_W-1:0]  timer_reg;
  logic [TMR_W-1:0]  capture_reg;
  logic [TMR_W-1:0]  compare_reg;
  logic [15:0]       frame_reg;
  logic [3:0]        div_reg;
  logic              tick_q_reg;
  logic [2:0]        bus_sync_reg;
  logic [2:0]        osc_sync_reg;
  logic [31:0]       rdata_next;
  logic [TMR_W-1:0]  width_count;
  logic              width_done;
  logic              width_running;
  logic              link_mode;
  logic              sync_tick;
  logic              bus_fall;
  logic              bus_rise;
  logic              osc_tick;
  logic              cmp_hit;
  logic              wr_status;
  pbl_pkg::pbl_bit_class_t class_next;

  assign link_mode = ctrl_reg[`PBL_CTL_LINK_MODE];

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for bus line and oscillator, third stage for edges
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bus_sync_reg <= 3'h7;
      osc_sync_reg <= 3'h0;
    end
    else
    begin
      bus_sync_reg <= {bus_sync_reg[1:0], bus_in};
      osc_sync_reg <= {osc_sync_reg[1:0], lp_osc};
    end
  end

  // edges seen only after the second stage
  assign bus_fall = bus_sync_reg[2] && !bus_sync_reg[1];
  assign bus_rise = !bus_sync_reg[2] && bus_sync_reg[1];
  assign osc_tick = !osc_sync_reg[2] && osc_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // 5 MHz prescaler, free-running
  always_ff @(posedge mclk)
  begin
    if (reset)
      div_reg <= 4'h0;
    else if (div_reg == SYNC_DIV_LAST)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  assign sync_tick = div_reg == SYNC_DIV_LAST;

  // sync timer runs without stopping in link mode and wraps
  always_ff @(posedge mclk)
  begin
    if (reset)
      timer_reg <= '0;
    else if (link_mode && sync_tick)
      timer_reg <= timer_reg + 1'b1;
  end

  // marks the cycle right after the timer advanced
  always_ff @(posedge mclk)
  begin
    if (reset)
      tick_q_reg <= 1'b0;
    else
      tick_q_reg <= link_mode && sync_tick;
  end

  // capture of the sync timer on each falling edge in link mode
  always_ff @(posedge mclk)
  begin
    if (reset)
      capture_reg <= TMR_W'(`PBL_RST_CAPTURE);
    else if (link_mode && bus_fall)
      capture_reg <= timer_reg;
  end

  // full-width equality once per timer step
  assign cmp_hit = link_mode && ctrl_reg[`PBL_CTL_CMP_EN] && tick_q_reg
                   && timer_reg == compare_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // low-pulse width measurement
  pbl_low_pulse_timer #(
    .WIDTH (TMR_W)
  ) u_width (
    .mclk      (mclk),
    .reset     (reset),
    .enable    (link_mode && ctrl_reg[`PBL_CTL_WIDTH_EN]),
    .fall      (bus_fall),
    .rise      (bus_rise),
    .osc_tick  (osc_tick),
    .count_reg (width_count),
    .done      (width_done),
    .running   (width_running)
  );

  // classify the finished pulse into sync, zero, one or invalid
  always_comb
  begin
    if (width_count <= SYNC_MAX)
      class_next = pbl_pkg::PBL_BIT_SYNC;
    else if (width_count <= ZERO_MAX)
      class_next = pbl_pkg::PBL_BIT_ZERO;
    else if (width_count <= ONE_MAX)
      class_next = pbl_pkg::PBL_BIT_ONE;
    else
      class_next = pbl_pkg::PBL_BIT_INVALID;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register, drive bit is released by hardware on compare if asked
  always_ff @(posedge mclk)
  begin
    if (reset)
      ctrl_reg <= `PBL_RST_CTRL;
    else if (reg_wr && reg_addr == `PBL_OFF_CTRL)
      ctrl_reg <= reg_wdata[15:0];
    else if (cmp_hit && ctrl_reg[`PBL_CTL_AUTO_REL])
      ctrl_reg[`PBL_CTL_DRIVE_LOW] <= 1'b0;
  end

  // compare register and frame check scratch
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      compare_reg <= TMR_W'(`PBL_RST_COMPARE);
      frame_reg   <= 16'h0000;
    end
    else if (reg_wr && reg_addr == `PBL_OFF_COMPARE)
      compare_reg <= reg_wdata[TMR_W-1:0];
    else if (reg_wr && reg_addr == `PBL_OFF_FRAME_CHK)
      frame_reg <= reg_wdata[15:0];
  end

  // sticky status, write one to clear, a new event wins over the clear
  assign wr_status = reg_wr && reg_addr == `PBL_OFF_STATUS;

  always_ff @(posedge mclk)
  begin
    if (reset)
      status_reg <= 6'h00;
    else
    begin
      if (ctrl_reg[`PBL_CTL_WAKE_EN] && bus_fall)
        status_reg[`PBL_STA_WAKE] <= 1'b1;
      else if (wr_status && reg_wdata[`PBL_STA_WAKE])
        status_reg[`PBL_STA_WAKE] <= 1'b0;
      if (width_done)
        status_reg[`PBL_STA_WIDTH_DONE] <= 1'b1;
      else if (wr_status && reg_wdata[`PBL_STA_WIDTH_DONE])
        status_reg[`PBL_STA_WIDTH_DONE] <= 1'b0;
      if (cmp_hit)
        status_reg[`PBL_STA_CMP] <= 1'b1;
      else if (wr_status && reg_wdata[`PBL_STA_CMP])
        status_reg[`PBL_STA_CMP] <= 1'b0;
      if (width_done)
        status_reg[`PBL_STA_CLASS_LO +: 2] <= class_next;
      status_reg[2] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      `PBL_OFF_CTRL:      rdata_next[15:0] = ctrl_reg;
      `PBL_OFF_STATUS:    rdata_next[5:0] = status_reg;
      `PBL_OFF_SYNC_TMR:  rdata_next[TMR_W-1:0] = timer_reg;
      `PBL_OFF_WIDTH_TMR: rdata_next[TMR_W-1:0] = width_count;
      `PBL_OFF_FRAME_CHK: rdata_next[17:0] = {odd_parity(frame_reg[15:8]),
                                              odd_parity(frame_reg[7:0]),
                                              frame_reg};
      `PBL_OFF_CAPTURE:   rdata_next[TMR_W-1:0] = capture_reg;
      `PBL_OFF_COMPARE:   rdata_next[TMR_W-1:0] = compare_reg;
      default:            rdata_next = 32'h0000_0000;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain line driver under software control, also used for the acknowledge
  assign bus_out  = 1'b0;
  assign bus_oe_n = !ctrl_reg[`PBL_CTL_DRIVE_LOW];

  // interrupt request levels straight from sticky status
  assign cmp_irq   = status_reg[`PBL_STA_CMP];
  assign width_irq = status_reg[`PBL_STA_WIDTH_DONE];
  assign wake_irq  = status_reg[`PBL_STA_WAKE];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_prescale;
    @(posedge mclk) disable iff (reset)
    sync_tick |=> !sync_tick [*8] ##1 !sync_tick ##1 sync_tick;
  endproperty
  a_prescale: assert property (p_prescale) else $error("sync tick not every ten cycles");

  property p_timer_step;
    @(posedge mclk) disable iff (reset)
    link_mode && sync_tick |=> timer_reg == TMR_W'($past(timer_reg) + 1'b1);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("sync timer did not step");

  property p_timer_hold;
    @(posedge mclk) disable iff (reset)
    !link_mode |=> $stable(timer_reg);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("sync timer moved outside link mode");

  property p_capture;
    @(posedge mclk) disable iff (reset)
    link_mode && bus_fall |=> capture_reg == $past(timer_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed falling edge");

  property p_cmp_set;
    @(posedge mclk) disable iff (reset)
    link_mode && ctrl_reg[`PBL_CTL_CMP_EN] && tick_q_reg && timer_reg == compare_reg
      |=> status_reg[`PBL_STA_CMP] && cmp_irq;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare match not flagged");

  property p_cmp_quiet;
    @(posedge mclk) disable iff (reset)
    !ctrl_reg[`PBL_CTL_CMP_EN] && !status_reg[`PBL_STA_CMP] |=> !status_reg[`PBL_STA_CMP];
  endproperty
  a_cmp_quiet: assert property (p_cmp_quiet) else $error("compare flag without enable");

  property p_width_clear;
    @(posedge mclk) disable iff (reset)
    link_mode && ctrl_reg[`PBL_CTL_WIDTH_EN] && bus_fall && !width_running
      |=> width_count == '0 && width_running;
  endproperty
  a_width_clear: assert property (p_width_clear) else $error("width timer not restarted");

  property p_width_done;
    @(posedge mclk) disable iff (reset)
    link_mode && ctrl_reg[`PBL_CTL_WIDTH_EN] && bus_rise && width_running
      |=> status_reg[`PBL_STA_WIDTH_DONE] && !width_running ##1 $stable(width_count);
  endproperty
  a_width_done: assert property (p_width_done) else $error("width timer did not stop");

  property p_wake;
    @(posedge mclk) disable iff (reset)
    ctrl_reg[`PBL_CTL_WAKE_EN] && bus_fall |=> wake_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("start condition not flagged");

  property p_release;
    @(posedge mclk) disable iff (reset)
    cmp_hit && ctrl_reg[`PBL_CTL_AUTO_REL] && !reg_wr |=> bus_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("line not released on compare");

  property p_rd_capture;
    @(posedge mclk) disable iff (reset)
    reg_rd && reg_addr == `PBL_OFF_CAPTURE |=> reg_rdata == {16'h0000, $past(capture_reg)};
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("capture read data wrong");

  c_capture: cover property (@(posedge mclk) disable iff (reset) link_mode && bus_fall);
  c_compare: cover property (@(posedge mclk) disable iff (reset) cmp_hit);
  c_width:   cover property (@(posedge mclk) disable iff (reset) width_done);
  c_wake:    cover property (@(posedge mclk) disable iff (reset) ctrl_reg[`PBL_CTL_WAKE_EN] && bus_fall);

endmodule : pbl_link_assist

`default_nettype wire

// file: dv/pbl_master_node.sv
// bus master node model: opens each bit cell by pulling the link low
`default_nettype none

module pbl_master_node (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [15:0] low_cycles,
  output logic             pull_low
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] cnt_reg;

  // holds the line low for the requested time, then lets the pull-up win
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_reg  <= 16'h0000;
      pull_low <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg  <= low_cycles;
      pull_low <= 1'b1;
    end
    else if (cnt_reg != 16'h0000)
      cnt_reg <= cnt_reg - 16'h0001;
    else
      pull_low <= 1'b0;
  end

endmodule : pbl_master_node

`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the pulse-width link timing assist
`include "pbl_defs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int max_cycles = 40000;

  logic        mclk      = 1'b0;
  logic        reset     = 1'b1;
  logic [31:0] reg_addr  = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        bus_out;
  logic        bus_oe_n;
  logic        cmp_irq;
  logic        width_irq;
  logic        wake_irq;
  logic        lp_osc    = 1'b0;
  logic [1:0]  lp_div    = 2'h0;
  logic        m_start   = 1'b0;
  logic [15:0] m_low     = 16'h0;
  logic        m_pull;
  logic        line;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          t_cur;
  int          t_prev;
  logic [31:0] d;
  logic [31:0] cap;
  logic [7:0]  hdr;
  logic [7:0]  dat;
  logic [15:0] widths [4] = '{16'h003C, 16'h00A0, 16'h0118, 16'h01B8};
  pbl_pkg::pbl_bit_class_t cls [4] = '{pbl_pkg::PBL_BIT_SYNC, pbl_pkg::PBL_BIT_ZERO,
                                       pbl_pkg::PBL_BIT_ONE, pbl_pkg::PBL_BIT_INVALID};

  // open-drain link with pull-up: low if either party pulls it
  assign line = ~m_pull & (bus_oe_n | bus_out);

  pbl_link_assist DUT (
    .mclk      (mclk),
    .reset     (reset),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .bus_in    (line),
    .bus_out   (bus_out),
    .bus_oe_n  (bus_oe_n),
    .lp_osc    (lp_osc),
    .cmp_irq   (cmp_irq),
    .width_irq (width_irq),
    .wake_irq  (wake_irq)
  );

  pbl_master_node u_master (
    .mclk       (mclk),
    .reset      (reset),
    .start      (m_start),
    .low_cycles (m_low),
    .pull_low   (m_pull)
  );

  // 50 MHz main clock
  always #10 mclk = ~mclk;

  // cycle count, slow oscillator of four main cycles, hang guard
  always @(posedge mclk)
  begin
    cyc    <= cyc + 1;
    lp_div <= lp_div + 2'h1;
    lp_osc <= lp_div[1];
    if (cyc == max_cycles)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // starts a master low pulse on a 500-cycle slot so capture gaps are exact
  task automatic pulse(input logic [15:0] w);
    do
      @(posedge mclk);
    while (cyc % 500 != 0);
    t_cur = cyc;
    m_low   <= w;
    m_start <= 1'b1;
    @(posedge mclk);
    m_start <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd(`PBL_OFF_CAPTURE, d);
    chk(d, 32'h0);
    @(posedge mclk);
    #1 chk(reg_rdata, 32'h0);
    rd(`PBL_OFF_COMPARE, d);
    chk(d, 32'h0);
    wr(`PBL_OFF_COMPARE, 32'hFFFFA5C3);
    rd(`PBL_OFF_COMPARE, d);
    chk(d, 32'h0000A5C3);
    wr(`PBL_OFF_CAPTURE, 32'h00001234);
    rd(`PBL_OFF_CAPTURE, d);
    chk(d, 32'h0);
    rd(32'hFFFF07A0, d);
    chk(d, 32'h0);
    // link mode off: only the wake-up path reacts to a fall
    wr(`PBL_OFF_CTRL, 32'h00000008);
    pulse(16'h003C);
    repeat (80) @(posedge mclk);
    chk({31'h0, wake_irq}, 32'h1);
    chk({31'h0, width_irq}, 32'h0);
    rd(`PBL_OFF_CAPTURE, d);
    chk(d, 32'h0);
    rd(`PBL_OFF_SYNC_TMR, d);
    chk(d, 32'h0);
    wr(`PBL_OFF_STATUS, 32'h00000001);
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, wake_irq}, 32'h0);
    // link mode with width timer: free-running timer, then each bit class
    wr(`PBL_OFF_CTRL, 32'h00000140);
    rd(`PBL_OFF_SYNC_TMR, d);
    repeat (98) @(posedge mclk);
    rd(`PBL_OFF_SYNC_TMR, cap);
    chk({16'h0, cap[15:0] - d[15:0]}, 32'h0000000A);
    for (int k = 0; k < 3; k++)
      pulse(16'h003C);
    for (int i = 0; i < 4; i++)
    begin
      pulse(widths[i]);
      repeat (int'(widths[i]) + 10) @(posedge mclk);
      rd(`PBL_OFF_STATUS, d);
      chk(d, {26'h0, cls[i], 4'h2});
      chk({31'h0, width_irq}, 32'h1);
      rd(`PBL_OFF_WIDTH_TMR, d);
      chk({31'h0, d[15:0] + 16'h2 >= (widths[i] >> 2) && d[15:0] <= (widths[i] >> 2) + 16'h2}, 32'h1);
      rd(`PBL_OFF_CAPTURE, d);
      if (i > 0)
        chk({16'h0, d[15:0] - cap[15:0]}, 32'((t_cur - t_prev) / 10));
      cap = d;
      t_prev = t_cur;
      wr(`PBL_OFF_STATUS, 32'h00000002);
    end
    // slave answers a master-opened cell with a one, ended by the compare
    wr(`PBL_OFF_CTRL, 32'h00002160);
    pulse(16'h0028);
    repeat (6) @(posedge mclk);
    rd(`PBL_OFF_CAPTURE, cap);
    wr(`PBL_OFF_COMPARE, {16'h0, cap[15:0] + 16'h001E});
    wr(`PBL_OFF_CTRL, 32'h00003160);
    while (cyc < t_cur + 250) @(posedge mclk);
    chk({31'h0, cmp_irq}, 32'h0);
    chk({31'h0, bus_oe_n}, 32'h0);
    chk({31'h0, bus_out}, 32'h0);
    while (cyc < t_cur + 360) @(posedge mclk);
    chk({31'h0, cmp_irq}, 32'h1);
    chk({31'h0, bus_oe_n}, 32'h1);
    rd(`PBL_OFF_STATUS, d);
    chk(d, {26'h0, pbl_pkg::PBL_BIT_ONE, 4'hA});
    // compare and width flags clear by writing ones, class stays
    wr(`PBL_OFF_STATUS, 32'h0000000A);
    rd(`PBL_OFF_STATUS, d);
    chk(d, {26'h0, pbl_pkg::PBL_BIT_ONE, 4'h0});
    chk({31'h0, cmp_irq}, 32'h0);
    // header and payload parity of write requests from the master
    for (int i = 0; i < 4; i++)
    begin
      hdr = {1'b0, 3'(i), 1'b1, 3'(3 * i)};
      dat = 8'h3C + 8'(i * 37);
      wr(`PBL_OFF_FRAME_CHK, {16'h0, dat, hdr});
      rd(`PBL_OFF_FRAME_CHK, d);
      chk(d, {14'h0, ^dat, ^hdr, dat, hdr});
    end
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
